// ==== hw/alarm_trim_regs.vh ====
`ifndef ALARM_TRIM_REGS_VH
`define ALARM_TRIM_REGS_VH

// Register offsets on the register port.
`define ADDR_ALARM_SUMMARY 10'h2c0
`define ADDR_ALARM_STATUS 10'h2c1
`define ADDR_ALARM_MASK 10'h2c2
`define ADDR_LANE_FLAGS 10'h2c4
`define ADDR_PIN_ROUTE 10'h2c6
`define ADDR_TRIM_A_DUAL 10'h310
`define ADDR_TRIM_B_DUAL 10'h313
`define ADDR_TRIM_A_SINGLE 10'h314

// Reset values.
`define RST_ALARM_STATUS 6'h3f
`define RST_ALARM_MASK 8'h3f
`define RST_LANE_FLAGS 16'hffff
`define RST_TRIM 8'h00
`define RST_PIN_ROUTE 1'h0
`define RST_STATUS_RESERVED 2'h0

// Bit positions of the alarm status and mask fields.
`define BIT_DIVIDER_MISMATCH 0
`define BIT_OSC_PHASE_UPSET 1
`define BIT_CLOCK_REALIGN 2
`define BIT_LINK_DOWN 3
`define BIT_PLL_UNLOCK 4
`define BIT_FIFO_ERROR 5

// Field widths.
`define ALARM_BITS 6
`define LANE_COUNT 16
`define TRIM_BITS 8
`define DATA_BITS 16
`define ADDR_BITS 10

`endif

// ==== hw/sticky_flag_bank.v ====
`timescale 1ns/1ps
`default_nettype none

// A row of sticky flags: a set input wins over a clear in the same cycle.
module sticky_flag_bank #(
   parameter WIDTH = 16,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
   // Clock and reset.
   input wire clk_sys,
   input wire resetn,
   // Per-bit set and clear requests.
   input wire [WIDTH-1:0] setFlag,
   input wire [WIDTH-1:0] clearFlag,
   // Current flag state.
   output wire [WIDTH-1:0] flags
);

   reg [WIDTH-1:0] flagState;
   genvar i;

   // Each flag keeps its value unless set or cleared; set has priority.
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : gen_flag
         always @(posedge clk_sys)
         begin
            if (!resetn)
            begin
               flagState[i] <= RESET_VALUE[i];
            end
            else if (setFlag[i])
            begin
               flagState[i] <= 1'b1;
            end
            else if (clearFlag[i])
            begin
               flagState[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flagState;

endmodule
`default_nettype wire

// ==== hw/alarm_mask_and_timing_trim.v ====
// How it works
// R1: Set mask bit keeps its alarm from summary.
// R2: Mask resets to 0x3f; bits 7:6 reserved.
// R3: Lane FIFO error sets that lane's flag.
// R4: Writing one clears lane flag; zeros ignored.
// R5: Persisting lane error sets flag again; set wins.
// R6: Clearing fifo status bit clears all lane flags.
// R7: Lane flags reset to all ones.
// R8: Trim registers drive core sampling adjust by mode.
// R9: Trims load factory defaults; software reads, overwrites.
// R10: Dual mode applies first trim to core A.
// R11: Dual mode with calibration: second trim, core B.
// R12: Single mode on pair A: dedicated core A trim.
// R13: Summary reads one when unmasked alarm set.
// R14: Fifo status sets on lane error; write-one clears.
// R15: All alarm status bits set after reset.
// R16: Reserved mask bits store, never affect alarms.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_trim_regs.vh"

module alarm_mask_and_timing_trim (
   // Clock and synchronous active-low reset.
   input wire clk_sys,
   input wire resetn,
   // Register port.
   input wire [`ADDR_BITS-1:0] regAddr,
   input wire [`DATA_BITS-1:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [`DATA_BITS-1:0] regRdData,
   // Alarm sources from the device core, same clock.
   input wire pllUnlock,
   input wire linkDown,
   input wire clockRealign,
   input wire oscillatorPhaseUpset,
   input wire dividerMismatch,
   input wire [`LANE_COUNT-1:0] laneFifoError,
   // Operating mode of the converter cores.
   input wire dualChannelMode,
   input wire foregroundCalEnable,
   input wire sampleInputPairA,
   // Factory trim load from the fuse memory.
   input wire trimLoad,
   input wire [`TRIM_BITS-1:0] fuseTrimADual,
   input wire [`TRIM_BITS-1:0] fuseTrimBDual,
   input wire [`TRIM_BITS-1:0] fuseTrimASingle,
   // Timing adjust values applied to the cores.
   output reg [`TRIM_BITS-1:0] coreATrim,
   output reg [`TRIM_BITS-1:0] coreBTrim,
   output reg coreBTrimApply,
   // Alarm outputs.
   output wire alarmIrq,
   output wire calibrationStatusPin
);

   // Returns one when a strobe is addressed to the given offset.
   function hit;
      input strobe;
      input [`ADDR_BITS-1:0] addr;
      input [`ADDR_BITS-1:0] target;
      begin
         hit = strobe && (addr == target);
      end
   endfunction

   // Control registers.
   reg [7:0] alarmMask;
   reg [1:0] statusReserved;
   reg pinRoute;
   reg [`TRIM_BITS-1:0] trimADual;
   reg [`TRIM_BITS-1:0] trimBDual;
   reg [`TRIM_BITS-1:0] trimASingle;

   // Flag state and the requests that drive it.
   wire [`ALARM_BITS-1:0] alarmStatus;
   wire [`ALARM_BITS-1:0] alarmSet;
   wire [`ALARM_BITS-1:0] alarmClear;
   wire [`LANE_COUNT-1:0] laneFlags;
   wire [`LANE_COUNT-1:0] laneClear;
   wire alarmSummary;
   wire anyLaneError;
   wire writeStatus;
   wire writeLanes;

   // Write decodes for the two clearable registers.
   assign writeStatus = hit(regWrite, regAddr, `ADDR_ALARM_STATUS);
   assign writeLanes = hit(regWrite, regAddr, `ADDR_LANE_FLAGS);

   // Any lane error raises the fifo status bit as well.
   assign anyLaneError = |laneFifoError; // see R14

   // Set requests of the alarm status bits, one per source.
   assign alarmSet[`BIT_FIFO_ERROR] = anyLaneError; // see R14
   assign alarmSet[`BIT_PLL_UNLOCK] = pllUnlock;
   assign alarmSet[`BIT_LINK_DOWN] = linkDown;
   assign alarmSet[`BIT_CLOCK_REALIGN] = clockRealign;
   assign alarmSet[`BIT_OSC_PHASE_UPSET] = oscillatorPhaseUpset;
   assign alarmSet[`BIT_DIVIDER_MISMATCH] = dividerMismatch;

   // Writing ones to the status register clears those bits.
   assign alarmClear = writeStatus ? regWrData[`ALARM_BITS-1:0] : {`ALARM_BITS{1'b0}}; // see R14

   // Lane flags clear by their own write or by clearing the fifo status bit.
   assign laneClear = (writeLanes ? regWrData : {`LANE_COUNT{1'b0}}) // see R4
      | ((writeStatus && regWrData[`BIT_FIFO_ERROR]) ? {`LANE_COUNT{1'b1}}
      : {`LANE_COUNT{1'b0}}); // see R6

   // Alarm status bits, all set after reset.
   sticky_flag_bank #(
      .WIDTH(`ALARM_BITS),
      .RESET_VALUE(`RST_ALARM_STATUS)
   ) statusBank (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .setFlag(alarmSet),
      .clearFlag(alarmClear),
      .flags(alarmStatus)
   ); // see R15

   // Per-lane FIFO error flags; a persisting error outranks a clear.
   sticky_flag_bank #(
      .WIDTH(`LANE_COUNT),
      .RESET_VALUE(`RST_LANE_FLAGS)
   ) laneBank (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .setFlag(laneFifoError), // see R3
      .clearFlag(laneClear),
      .flags(laneFlags)
   ); // see R5, see R7

   // Summary alarm: only status bits whose mask bit is clear count.
   assign alarmSummary = |(alarmStatus & ~alarmMask[`ALARM_BITS-1:0]); // see R1, see R13, see R16

   // The summary is the level interrupt; it may also be routed to the pin.
   assign alarmIrq = alarmSummary;
   assign calibrationStatusPin = pinRoute & alarmSummary; // see R13

   // Mask register and reserved status bits; mask resets to all masked.
   always @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         alarmMask <= `RST_ALARM_MASK; // see R2
         statusReserved <= `RST_STATUS_RESERVED;
         pinRoute <= `RST_PIN_ROUTE;
      end
      else
      begin
         if (hit(regWrite, regAddr, `ADDR_ALARM_MASK))
         begin
            alarmMask <= regWrData[7:0]; // see R16
         end
         if (writeStatus)
         begin
            statusReserved <= regWrData[7:6];
         end
         if (hit(regWrite, regAddr, `ADDR_PIN_ROUTE))
         begin
            pinRoute <= regWrData[0];
         end
      end
   end

   // Trim registers: fuse load brings factory values, software may overwrite.
   always @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         trimADual <= `RST_TRIM;
         trimBDual <= `RST_TRIM;
         trimASingle <= `RST_TRIM;
      end
      else if (trimLoad)
      begin
         trimADual <= fuseTrimADual; // see R9
         trimBDual <= fuseTrimBDual;
         trimASingle <= fuseTrimASingle;
      end
      else
      begin
         if (hit(regWrite, regAddr, `ADDR_TRIM_A_DUAL))
         begin
            trimADual <= regWrData[`TRIM_BITS-1:0]; // see R9
         end
         if (hit(regWrite, regAddr, `ADDR_TRIM_B_DUAL))
         begin
            trimBDual <= regWrData[`TRIM_BITS-1:0];
         end
         if (hit(regWrite, regAddr, `ADDR_TRIM_A_SINGLE))
         begin
            trimASingle <= regWrData[`TRIM_BITS-1:0];
         end
      end
   end

   // Select the trim each core uses from the operating mode.
   always @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         coreATrim <= `RST_TRIM;
         coreBTrim <= `RST_TRIM;
         coreBTrimApply <= 1'b0;
      end
      else
      begin
         if (dualChannelMode)
         begin
            coreATrim <= trimADual; // see R8, see R10
         end
         else if (sampleInputPairA)
         begin
            coreATrim <= trimASingle; // see R12
         end
         else
         begin
            coreATrim <= trimADual;
         end
         coreBTrim <= trimBDual; // see R8
         coreBTrimApply <= dualChannelMode && foregroundCalEnable; // see R11
      end
   end

   // Read data stands only in the cycle after the read strobe.
   always @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         regRdData <= 16'h0000;
      end
      else if (regRead)
      begin
         case (regAddr)
            `ADDR_ALARM_SUMMARY: regRdData <= {15'h0000, alarmSummary}; // see R13
            `ADDR_ALARM_STATUS: regRdData <= {8'h00, statusReserved, alarmStatus};
            `ADDR_ALARM_MASK: regRdData <= {8'h00, alarmMask};
            `ADDR_LANE_FLAGS: regRdData <= laneFlags;
            `ADDR_PIN_ROUTE: regRdData <= {15'h0000, pinRoute};
            `ADDR_TRIM_A_DUAL: regRdData <= {8'h00, trimADual}; // see R9
            `ADDR_TRIM_B_DUAL: regRdData <= {8'h00, trimBDual};
            `ADDR_TRIM_A_SINGLE: regRdData <= {8'h00, trimASingle};
            default: regRdData <= 16'h0000;
         endcase
      end
      else
      begin
         regRdData <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

// ==== tb/alarm_trim_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the register port and core outputs for priority and timing slips.
module alarm_trim_checker (
   // Clock, reset and register port.
   input wire clk_sys,
   input wire resetn,
   input wire [9:0] regAddr,
   input wire [15:0] regWrData,
   input wire regWrite,
   input wire regRead,
   input wire [15:0] regRdData,
   // Core side.
   input wire [15:0] laneFifoError,
   input wire dualChannelMode,
   input wire foregroundCalEnable,
   input wire trimLoad,
   input wire [7:0] coreATrim,
   input wire coreBTrimApply,
   input wire alarmIrq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Decoded lane register strobes.
   wire rdL = regRead && regAddr == 10'h2c4;
   wire wrL = regWrite && regAddr == 10'h2c4;
   property p_irqRst; !$past(resetn) |-> !alarmIrq; endproperty
   a_irqRst: assert property (p_irqRst) else $error("irq set after reset");
   property p_sumRd; regRead && regAddr == 10'h2c0 |=> regRdData == {15'h0, $past(alarmIrq)}; endproperty
   a_sumRd: assert property (p_sumRd) else $error("summary differs from irq");
   property p_laneSet; laneFifoError[3] ##1 rdL |=> regRdData[3]; endproperty
   a_laneSet: assert property (p_laneSet) else $error("lane flag not set");
   property p_laneClr; wrL && regWrData[1] && !laneFifoError[1] ##1 rdL |=> !regRdData[1]; endproperty
   a_laneClr: assert property (p_laneClr) else $error("lane flag not cleared");
   property p_setWins; wrL && regWrData[2] && laneFifoError[2] ##1 rdL |=> regRdData[2]; endproperty
   a_setWins: assert property (p_setWins) else $error("clear beat set");
   property p_fifoAll;
      regWrite && regAddr == 10'h2c1 && regWrData[5] && laneFifoError == 0 ##1 rdL |=> regRdData == 0;
   endproperty
   a_fifoAll: assert property (p_fifoAll) else $error("lane flags kept");
   property p_fifoSt; |laneFifoError ##1 (regRead && regAddr == 10'h2c1) |=> regRdData[5]; endproperty
   a_fifoSt: assert property (p_fifoSt) else $error("fifo status not set");
   property p_applyB; 1'b1 |=> coreBTrimApply == ($past(dualChannelMode) && $past(foregroundCalEnable)); endproperty
   a_applyB: assert property (p_applyB) else $error("core B apply wrong");
   property p_trimA;
      regWrite && regAddr == 10'h310 && !trimLoad && dualChannelMode ##1 dualChannelMode
         |=> coreATrim == $past(regWrData[7:0], 2);
   endproperty
   a_trimA: assert property (p_trimA) else $error("core A trim wrong");
   c_wrL: cover property (wrL);
   c_rdL: cover property (rdL ##1 regRdData != 0);
   c_apply: cover property (coreBTrimApply);
endmodule
bind alarm_mask_and_timing_trim alarm_trim_checker u_chk (.clk_sys, .resetn, .regAddr, .regWrData,
   .regWrite, .regRead, .regRdData, .laneFifoError, .dualChannelMode, .foregroundCalEnable,
   .trimLoad, .coreATrim, .coreBTrimApply, .alarmIrq);
`default_nettype wire

// ==== tb/alarm_mask_and_timing_trim_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module alarm_mask_and_timing_trim_test;
   logic clk_sys = 0;
   logic resetn = 0;
   logic [9:0] regAddr = 0;
   logic [15:0] regWrData = 0;
   logic regWrite = 0;
   logic regRead = 0;
   logic [4:0] src = 0;
   logic [15:0] laneFifoError = 0;
   logic [2:0] mode = 0;
   logic trimLoad = 0;
   logic [7:0] fa = 0, fb = 0, fs = 0;
   logic [15:0] v;
   wire [15:0] regRdData;
   wire [7:0] coreATrim, coreBTrim;
   wire coreBTrimApply, alarmIrq, calibrationStatusPin;
   integer st = 16'h3f, mk = 16'h3f, ln = 16'hffff, ta = 0, tb = 0, ts = 0, rt = 0;
   integer errCount = 0, testsRun = 0, seed = 52, i;
   alarm_mask_and_timing_trim dut (.clk_sys, .resetn, .regAddr, .regWrData, .regWrite, .regRead,
      .regRdData, .pllUnlock(src[4]), .linkDown(src[3]), .clockRealign(src[2]),
      .oscillatorPhaseUpset(src[1]), .dividerMismatch(src[0]), .laneFifoError,
      .dualChannelMode(mode[2]), .foregroundCalEnable(mode[1]), .sampleInputPairA(mode[0]),
      .trimLoad, .fuseTrimADual(fa), .fuseTrimBDual(fb), .fuseTrimASingle(fs), .coreATrim,
      .coreBTrim, .coreBTrimApply, .alarmIrq, .calibrationStatusPin);
   // Free-running system clock.
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end
   // Summary alarm predicted by the model.
   function logic irqf(input integer x);
      irqf = |(st & ~mk & 16'h3f);
   endfunction
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         testsRun = testsRun + 1;
         if (seen !== exp)
         begin
            errCount = errCount + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // One write cycle; the model follows the register effects.
   task wr(input [9:0] a, input [15:0] d);
      begin
         regWrite <= 1;
         regAddr <= a;
         regWrData <= d;
         @(posedge clk_sys);
         regWrite <= 0;
         case (a)
            10'h2c1: st = (st & ~d & 16'h3f) | (d & 16'hc0);
            10'h2c2: mk = d & 16'hff;
            10'h2c4: ln = ln & ~d;
            10'h2c6: rt = d & 16'h1;
            10'h310: ta = d & 16'hff;
            10'h313: tb = d & 16'hff;
            10'h314: ts = d & 16'hff;
         endcase
         if (a == 10'h2c1 && d[5])
            ln = 0;
      end
   endtask
   // One read cycle, then the data and the alarm outputs are compared.
   task rd(input [9:0] a, input [15:0] e);
      begin
         regRead <= 1;
         regAddr <= a;
         @(posedge clk_sys);
         regRead <= 0;
         #1;
         chk(regRdData, e);
         chk({calibrationStatusPin, alarmIrq}, {irqf(0) & rt[0], irqf(0)});
         @(posedge clk_sys);
      end
   endtask
   // One-cycle alarm and lane error event.
   task ev(input [4:0] s, input [15:0] l);
      begin
         src <= s;
         laneFifoError <= l;
         @(posedge clk_sys);
         src <= 0;
         laneFifoError <= 0;
         st = st | s | (l != 0 ? 32 : 0);
         ln = ln | l;
      end
   endtask
   task giveVerdict;
      begin
         if (errCount == 0 && testsRun > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // Main sequence.
   initial
   begin
      repeat (5) @(posedge clk_sys);
      resetn <= 1;
      rd(10'h2c2, 16'h3f);
      rd(10'h2c4, 16'hffff);
      rd(10'h2c1, 16'h3f);
      rd(10'h200, 0);
      rd(10'h2c6, 0);
      wr(10'h2c6, 1);
      rd(10'h2c6, 1);
      wr(10'h2c1, 16'hff);
      rd(10'h2c4, 0);
      wr(10'h2c2, 16'hc0);
      rd(10'h2c2, 16'hc0);
      for (i = 0; i < 5; i = i + 1)
      begin
         ev(5'h1 << i, 0);
         rd(10'h2c1, st);
         rd(10'h2c0, irqf(0));
         wr(10'h2c2, mk | (1 << i));
         rd(10'h2c0, irqf(0));
         wr(10'h2c1, 1 << i);
         rd(10'h2c1, st);
         wr(10'h2c2, 16'hc0);
      end
      for (i = 0; i < 6; i = i + 1)
      begin
         v = 16'($random(seed));
         ev(0, v | 16'h8);
         rd(i[0] ? 10'h2c1 : 10'h2c4, i[0] ? st : ln);
         wr(10'h2c4, 16'($random(seed)) | 16'h2);
         rd(10'h2c4, ln);
      end
      laneFifoError <= 16'h4;
      wr(10'h2c4, 16'hffff);
      laneFifoError <= 0;
      ln = 4;
      st = st | 32;
      rd(10'h2c4, ln);
      fa <= 8'($random(seed));
      fb <= 8'($random(seed));
      fs <= 8'($random(seed));
      trimLoad <= 1;
      @(posedge clk_sys);
      trimLoad <= 0;
      ta = fa;
      tb = fb;
      ts = fs;
      rd(10'h313, tb);
      wr(10'h314, 16'($random(seed)));
      rd(10'h314, ts);
      for (i = 0; i < 8; i = i + 1)
      begin
         mode <= i;
         wr(10'h310, 16'($random(seed)));
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk(coreATrim, mode[2] || !mode[0] ? ta : ts);
         chk(coreBTrim, tb);
         chk(coreBTrimApply, mode[2] & mode[1]);
         @(posedge clk_sys);
      end
      rd(10'h310, ta);
      giveVerdict;
   end
endmodule
`default_nettype wire
